// ---- common/ets_pkg.sv ----
package ets_pkg;

  // parameter record contents, fixed at build time
  localparam logic [7:0] IN_LEN        = 8'h04;
  localparam logic [7:0] OUT_LEN_SMALL = 8'h14;
  localparam logic [7:0] OUT_LEN_LARGE = 8'h3C;
  localparam logic [1:0] PARAM_IDX_IN  = 2'h0;
  localparam logic [1:0] PARAM_IDX_OUT = 2'h1;

  // output image geometry
  localparam logic [3:0] SLOTS_SMALL   = 4'h5;
  localparam logic [3:0] SLOTS_LARGE   = 4'hF;
  localparam int         SLOT_MAX      = 15;
  localparam logic [1:0] BYTE_OUT      = 2'h0;
  localparam logic [1:0] BYTE_SEQ      = 2'h1;
  localparam logic [1:0] BYTE_TIME_HI  = 2'h2;
  localparam logic [1:0] BYTE_TIME_LO  = 2'h3;

  // queue geometry
  localparam int         FIFO_DEPTH    = 32;
  localparam int         FIFO_AW       = 5;
  localparam logic [5:0] FIFO_FULL     = 6'h20;

  // output byte fields
  localparam int         LVL0_BIT      = 7;
  localparam int         LVL1_BIT      = 6;
  localparam int         EN0_BIT       = 5;
  localparam int         EN1_BIT       = 4;

  // sequence number fields
  localparam int         SEQ_END_BIT   = 6;
  localparam logic [7:0] SEQ_END_MASK  = 8'h40;
  localparam logic [1:0] NEXT_MARK     = 2'h3;

  // queue status bits
  localparam int         STS_END_BIT   = 7;
  localparam int         STS_FULL_BIT  = 2;
  localparam int         STS_RUN_BIT   = 1;

  typedef struct packed {
    logic [7:0]  out_bits;
    logic [7:0]  seq;
    logic [15:0] time_us;
  } entry_t;

  typedef struct packed {
    logic [7:0] last_received_sequence;
    logic [7:0] next_pending_sequence;
    logic [7:0] queue_status;
    logic [7:0] queued_entry_count;
  } status_image_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_FETCH = 3'b010,
    S_CHECK = 3'b100
  } sched_state_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'b01,
    C_COPY = 2'b10
  } copy_state_t;

endpackage : ets_pkg

// ---- hw/ets_channel.sv ----
module ets_channel (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic apply,
  input  wire logic level,
  input  wire logic enable,
  output logic      drive_level
);

  logic level_ff;
  logic nxt_level;

  // level moves only when the entry enables this output
  always_comb begin
    nxt_level = level_ff;
    if (apply && enable) begin
      nxt_level = level;
    end
  end

  // output level register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign drive_level = level_ff;

endmodule : ets_channel

// ---- hw/ets_fifo_mem.sv ----
module ets_fifo_mem (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  wr_en,
  input  wire logic [4:0]            wr_addr,
  input  wire ets_pkg::entry_t       wr_data,
  input  wire logic                  clr_en,
  input  wire logic [4:0]            clr_addr,
  input  wire logic [4:0]            rd_addr,
  output ets_pkg::entry_t            rd_data
);

  ets_pkg::entry_t mem_ff     [ets_pkg::FIFO_DEPTH];
  ets_pkg::entry_t nxt_mem    [ets_pkg::FIFO_DEPTH];
  ets_pkg::entry_t rd_data_ff;
  ets_pkg::entry_t nxt_rd_data;

  // store on push, wipe the slot just issued so empty slots read zero
  always_comb begin
    for (int i = 0; i < ets_pkg::FIFO_DEPTH; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (wr_en) begin
      nxt_mem[wr_addr] = wr_data;
    end
    if (clr_en) begin
      nxt_mem[clr_addr] = '0;
    end
    nxt_rd_data = mem_ff[rd_addr];
  end

  // registered storage and read port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ets_pkg::FIFO_DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      rd_data_ff <= '0;
    end else begin
      for (int i = 0; i < ets_pkg::FIFO_DEPTH; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule : ets_fifo_mem

// ---- hw/timestamped_output_scheduler.sv ----
// What this block does
// - parameter record reports input image length four bytes, fixed
// - parameter record reports output image length 14h or 3Ch per variant
// - parameter values are constants; writes are refused and flagged
// - small variant holds five four-byte entries at consecutive offsets
// - committed image entries are appended to the queue after queued ones
// - entry byte bits 7,6 levels, bits 5,4 enables, applied at target time
// - an output changes level only when its enable bit is set
// - a due entry is applied and removed from the queue head in the same cycle
// - entries are issued strictly in order, one after another
// - input image shows last, next sequence, queue status and entry count
module timestamped_output_scheduler #(
  parameter logic LARGE_IMAGE = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [15:0]            us_ticker,
  input  wire logic                   piq_wr,
  input  wire logic [5:0]             piq_addr,
  input  wire logic [7:0]             piq_data,
  input  wire logic                   piq_commit,
  input  wire logic                   param_rd,
  input  wire logic [1:0]             param_idx,
  input  wire logic                   param_wr,
  output ets_pkg::status_image_t      input_process_image,
  output logic [7:0]                  param_data,
  output logic                        param_reject,
  output logic                        copy_busy,
  output logic [1:0]                  do_level
);

  localparam logic [3:0] SLOTS   = LARGE_IMAGE ? ets_pkg::SLOTS_LARGE : ets_pkg::SLOTS_SMALL;
  localparam logic [7:0] OUT_LEN = LARGE_IMAGE ? ets_pkg::OUT_LEN_LARGE : ets_pkg::OUT_LEN_SMALL;

  // output image copy
  ets_pkg::entry_t        image_ff  [ets_pkg::SLOT_MAX];
  ets_pkg::entry_t        nxt_image [ets_pkg::SLOT_MAX];

  // copy engine
  ets_pkg::copy_state_t   copy_ff;
  ets_pkg::copy_state_t   nxt_copy;
  logic [3:0]             slot_ff;
  logic [3:0]             nxt_slot;

  // queue pointers and counters
  logic [4:0]             head_ff;
  logic [4:0]             nxt_head;
  logic [4:0]             tail_ff;
  logic [4:0]             nxt_tail;
  logic [5:0]             count_ff;
  logic [5:0]             nxt_count;

  // scheduler
  ets_pkg::sched_state_t  sched_ff;
  ets_pkg::sched_state_t  nxt_sched;

  // status bookkeeping
  logic [7:0]             last_rx_ff;
  logic [7:0]             nxt_last_rx;
  logic [5:0]             next_seq_ff;
  logic [5:0]             nxt_next_seq;
  logic                   end_mark_ff;
  logic                   nxt_end_mark;
  logic                   started_ff;
  logic                   nxt_started;

  // registered outputs
  ets_pkg::status_image_t image_out_ff;
  ets_pkg::status_image_t nxt_image_out;
  logic [7:0]             param_data_ff;
  logic [7:0]             nxt_param_data;
  logic                   param_reject_ff;
  logic                   nxt_param_reject;

  // internal strobes
  logic                   push;
  logic                   pop;
  logic                   full;
  logic                   due;
  logic [15:0]            lag;
  ets_pkg::entry_t        push_entry;
  ets_pkg::entry_t        head_entry;
  logic                   batch_final;

  assign full       = (count_ff == ets_pkg::FIFO_FULL);
  assign push_entry = image_ff[slot_ff];
  assign lag        = us_ticker - head_entry.time_us;
  // wrap-safe compare: due once the ticker has reached the target
  assign due        = !lag[15];
  assign pop        = (sched_ff == ets_pkg::S_CHECK) && due;
  assign push       = (copy_ff == ets_pkg::C_COPY) && !full;
  assign batch_final = push_entry.seq[ets_pkg::SEQ_END_BIT] || (slot_ff == SLOTS - 4'h1);

  // byte writes into the output image, four bytes per slot
  always_comb begin
    logic [3:0] wslot;
    wslot = piq_addr[5:2];
    for (int i = 0; i < ets_pkg::SLOT_MAX; i++) begin
      nxt_image[i] = image_ff[i];
    end
    if (piq_wr && (wslot < SLOTS)) begin
      case (piq_addr[1:0])
        ets_pkg::BYTE_OUT:     nxt_image[wslot].out_bits      = piq_data;
        ets_pkg::BYTE_SEQ:     nxt_image[wslot].seq           = piq_data;
        ets_pkg::BYTE_TIME_HI: nxt_image[wslot].time_us[15:8] = piq_data;
        ets_pkg::BYTE_TIME_LO: nxt_image[wslot].time_us[7:0]  = piq_data;
        default:               nxt_image[wslot].out_bits      = image_ff[wslot].out_bits;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ets_pkg::SLOT_MAX; i++) begin
        image_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ets_pkg::SLOT_MAX; i++) begin
        image_ff[i] <= nxt_image[i];
      end
    end
  end

  // copy engine: walks the image slots into the queue, stalls while full
  always_comb begin
    nxt_copy     = copy_ff;
    nxt_slot     = slot_ff;
    nxt_last_rx  = last_rx_ff;
    nxt_end_mark = end_mark_ff;
    case (copy_ff)
      ets_pkg::C_IDLE: begin
        if (piq_commit) begin
          nxt_copy = ets_pkg::C_COPY;
          nxt_slot = 4'h0;
        end
      end
      ets_pkg::C_COPY: begin
        if (push) begin
          if (batch_final) begin
            // the final entry of a batch reports with its end bit set
            nxt_last_rx  = push_entry.seq | ets_pkg::SEQ_END_MASK;
            nxt_end_mark = push_entry.seq[ets_pkg::SEQ_END_BIT];
            nxt_copy     = ets_pkg::C_IDLE;
          end else begin
            nxt_slot = slot_ff + 4'h1;
          end
        end
      end
      default: begin
        nxt_copy = ets_pkg::C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      copy_ff     <= ets_pkg::C_IDLE;
      slot_ff     <= 4'h0;
      last_rx_ff  <= 8'h00;
      end_mark_ff <= 1'b0;
    end else begin
      copy_ff     <= nxt_copy;
      slot_ff     <= nxt_slot;
      last_rx_ff  <= nxt_last_rx;
      end_mark_ff <= nxt_end_mark;
    end
  end

  // queue pointers and occupancy count
  always_comb begin
    nxt_head  = head_ff;
    nxt_tail  = tail_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_tail = tail_ff + 5'h01;
    end
    if (pop) begin
      nxt_head = head_ff + 5'h01;
    end
    case ({push, pop})
      2'b10:   nxt_count = count_ff + 6'h01;
      2'b01:   nxt_count = count_ff - 6'h01;
      default: nxt_count = count_ff;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      head_ff  <= 5'h00;
      tail_ff  <= 5'h00;
      count_ff <= 6'h00;
    end else begin
      head_ff  <= nxt_head;
      tail_ff  <= nxt_tail;
      count_ff <= nxt_count;
    end
  end

  // scheduler: fetch head, wait for its time, issue, repeat
  always_comb begin
    nxt_sched    = sched_ff;
    nxt_started  = started_ff;
    nxt_next_seq = next_seq_ff;
    if (push && (count_ff == 6'h00)) begin
      nxt_next_seq = push_entry.seq[5:0];
    end
    case (sched_ff)
      ets_pkg::S_IDLE: begin
        if (count_ff != 6'h00) begin
          nxt_sched = ets_pkg::S_FETCH;
        end
      end
      ets_pkg::S_FETCH: begin
        // read data of the new head lands one cycle after the pointer moves
        if (count_ff != 6'h00) begin
          nxt_sched = ets_pkg::S_CHECK;
        end else begin
          nxt_sched = ets_pkg::S_IDLE;
        end
      end
      ets_pkg::S_CHECK: begin
        if (due) begin
          nxt_started  = 1'b1;
          nxt_next_seq = head_entry.seq[5:0] + 6'h01;
          nxt_sched    = ets_pkg::S_FETCH;
        end
      end
      default: begin
        nxt_sched = ets_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sched_ff    <= ets_pkg::S_IDLE;
      started_ff  <= 1'b0;
      next_seq_ff <= 6'h00;
    end else begin
      sched_ff    <= nxt_sched;
      started_ff  <= nxt_started;
      next_seq_ff <= nxt_next_seq;
    end
  end

  // status bytes and parameter record answers
  always_comb begin
    nxt_image_out                        = '0;
    nxt_image_out.last_received_sequence = last_rx_ff;
    nxt_image_out.next_pending_sequence  = {ets_pkg::NEXT_MARK, next_seq_ff};
    nxt_image_out.queue_status[ets_pkg::STS_END_BIT]  = end_mark_ff;
    nxt_image_out.queue_status[ets_pkg::STS_FULL_BIT] = full;
    nxt_image_out.queue_status[ets_pkg::STS_RUN_BIT]  = started_ff;
    nxt_image_out.queued_entry_count     = {2'b00, count_ff};
    nxt_param_data   = param_data_ff;
    nxt_param_reject = param_wr;
    if (param_rd) begin
      case (param_idx)
        ets_pkg::PARAM_IDX_IN:  nxt_param_data = ets_pkg::IN_LEN;
        ets_pkg::PARAM_IDX_OUT: nxt_param_data = OUT_LEN;
        default:                nxt_param_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      image_out_ff    <= '0;
      param_data_ff   <= 8'h00;
      param_reject_ff <= 1'b0;
    end else begin
      image_out_ff    <= nxt_image_out;
      param_data_ff   <= nxt_param_data;
      param_reject_ff <= nxt_param_reject;
    end
  end

  // queue storage, head slot wiped as it is issued
  ets_fifo_mem u_fifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .wr_en    (push),
    .wr_addr  (tail_ff),
    .wr_data  (push_entry),
    .clr_en   (pop),
    .clr_addr (head_ff),
    .rd_addr  (head_ff),
    .rd_data  (head_entry)
  );

  // output 0 takes bits 7 and 5 of the issued entry
  ets_channel u_out0 (
    .clk         (clk),
    .arst_n      (arst_n),
    .apply       (pop),
    .level       (head_entry.out_bits[ets_pkg::LVL0_BIT]),
    .enable      (head_entry.out_bits[ets_pkg::EN0_BIT]),
    .drive_level (do_level[0])
  );

  // output 1 takes bits 6 and 4 of the issued entry
  ets_channel u_out1 (
    .clk         (clk),
    .arst_n      (arst_n),
    .apply       (pop),
    .level       (head_entry.out_bits[ets_pkg::LVL1_BIT]),
    .enable      (head_entry.out_bits[ets_pkg::EN1_BIT]),
    .drive_level (do_level[1])
  );

  assign input_process_image = image_out_ff;
  assign param_data          = param_data_ff;
  assign param_reject        = param_reject_ff;
  assign copy_busy           = (copy_ff == ets_pkg::C_COPY);

endmodule : timestamped_output_scheduler

// ---- verif/ets_sched_sva.sv ----
module ets_sched_sva #(
  parameter logic LARGE_IMAGE = 1'b0
) (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic [15:0]            us_ticker,
  input wire logic                   piq_wr,
  input wire logic [5:0]             piq_addr,
  input wire logic [7:0]             piq_data,
  input wire logic                   piq_commit,
  input wire logic                   param_rd,
  input wire logic [1:0]             param_idx,
  input wire logic                   param_wr,
  input wire ets_pkg::status_image_t input_process_image,
  input wire logic [7:0]             param_data,
  input wire logic                   param_reject,
  input wire logic                   copy_busy,
  input wire logic [1:0]             do_level
);
  localparam logic [7:0] OUT_LEN = LARGE_IMAGE ? ets_pkg::OUT_LEN_LARGE : ets_pkg::OUT_LEN_SMALL;
  logic [7:0] cnt;
  logic [7:0] nxt;
  logic [7:0] sts;
  // short views of the status image
  assign cnt = input_process_image.queued_entry_count;
  assign nxt = input_process_image.next_pending_sequence;
  assign sts = input_process_image.queue_status;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_in_len: assert property (
    param_rd && param_idx == ets_pkg::PARAM_IDX_IN |=> param_data == ets_pkg::IN_LEN)
    else $error("input length record wrong");
  chk_out_len: assert property (
    param_rd && param_idx == ets_pkg::PARAM_IDX_OUT |=> param_data == OUT_LEN)
    else $error("output length record wrong");
  chk_wr_refused: assert property (
    param_wr |=> param_reject && $stable(param_data))
    else $error("parameter write not refused");
  chk_data_hold: assert property (
    !param_rd |=> $stable(param_data))
    else $error("parameter data changed unasked");
  chk_copy_start: assert property (
    piq_commit && !copy_busy |=> copy_busy)
    else $error("commit did not start copy");
  chk_issue_gap: assert property (
    !$stable(do_level) |=> $stable(do_level))
    else $error("issues closer than two cycles");
  chk_count_step: assert property (
    !$stable(cnt) |-> cnt == $past(cnt) + 8'h01 || cnt == $past(cnt) - 8'h01)
    else $error("entry count jumped");
  chk_count_max: assert property (
    cnt <= {2'b00, ets_pkg::FIFO_FULL})
    else $error("entry count above queue depth");
  chk_next_mark: assert property (
    cnt != 8'h00 |-> nxt[7:6] == ets_pkg::NEXT_MARK)
    else $error("next sequence mark missing");
  chk_issue_status: assert property (
    !$stable(do_level) |-> ##[0:3] sts[ets_pkg::STS_RUN_BIT])
    else $error("issue not shown in status");
endmodule : ets_sched_sva

// ---- verif/head_ticker.sv ----
module head_ticker #(
  parameter logic [15:0] STEP = 16'h0004
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        run,
  output logic [15:0]      us_ticker
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] tick_ff;
  logic [15:0] nxt_tick;
  // shared microsecond time base, stands still while not running
  always_comb begin
    nxt_tick = run ? tick_ff + STEP : tick_ff;
  end
  // ticker register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 16'h0000;
    end else begin
      tick_ff <= nxt_tick;
    end
  end
  assign us_ticker = tick_ff;
endmodule : head_ticker

// ---- verif/timestamped_output_scheduler_test.sv ----
module timestamped_output_scheduler_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk, arst_n, run, piq_wr, piq_commit, param_rd, param_wr, param_reject, copy_busy;
  logic [15:0]            us_ticker;
  logic [5:0]             piq_addr;
  logic [7:0]             piq_data, param_data;
  logic [1:0]             param_idx, do_level, lvl;
  ets_pkg::status_image_t img;
  int                     err_count, tests_run;
  // out byte, sequence, target time; 0..4 first batch, 5..7 short batch, 8..12 refill far ahead
  ets_pkg::entry_t        ent [13] = '{32'h3001_1770, 32'hB002_30DA, 32'hF003_86D6, 32'h3004_C176,
                                       32'h7005_D501, 32'hF006_DEA8, 32'h1007_E290, 32'h0048_E678,
                                       32'h0010_3498, 32'h0011_3498, 32'h0012_3498, 32'h0013_3498,
                                       32'h0014_3498};
  timestamped_output_scheduler #(.LARGE_IMAGE(1'b0)) timestamped_output_scheduler_inst (.clk, .arst_n,
    .us_ticker, .piq_wr, .piq_addr, .piq_data, .piq_commit, .param_rd, .param_idx, .param_wr,
    .input_process_image(img), .param_data, .param_reject, .copy_busy, .do_level);
  head_ticker head_ticker_inst (.clk, .arst_n, .run, .us_ticker);
  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
    piq_addr = a;
    piq_data = d;
    piq_wr = 1'b1;
    cyc;
    piq_wr = 1'b0;
    cyc;
  endtask : wr_byte
  task automatic param_get(input logic [1:0] i, input logic [7:0] exp);
    param_idx = i;
    param_rd = 1'b1;
    cyc;
    param_rd = 1'b0;
    chk(param_data, exp);
    cyc;
  endtask : param_get
  task automatic wait_cnt(input logic [7:0] c);
    for (int i = 0; i < 20000; i++) begin
      if (img.queued_entry_count === c) break;
      cyc;
    end
    // a count that never arrives is a mismatch
    chk(img.queued_entry_count, c);
  endtask : wait_cnt
  // write n slots from the table, then commit them to the queue
  task automatic load(input int f, input int n);
    for (int s = 0; s < n; s++) begin
      for (int b = 0; b < 4; b++) wr_byte({s[3:0], b[1:0]}, ent[f+s][31-8*b -: 8]);
    end
    piq_commit = 1'b1;
    cyc;
    piq_commit = 1'b0;
    wait_cnt(8'(n));
  endtask : load
  // let time run and follow each issue at the outputs
  task automatic exec(input int f, input int n);
    run = 1'b1;
    for (int k = 0; k < n; k++) begin
      wait_cnt(8'(n - 1 - k));
      lvl[1] = ent[f+k].out_bits[ets_pkg::EN1_BIT] ? ent[f+k].out_bits[ets_pkg::LVL1_BIT] : lvl[1];
      lvl[0] = ent[f+k].out_bits[ets_pkg::EN0_BIT] ? ent[f+k].out_bits[ets_pkg::LVL0_BIT] : lvl[0];
      chk({6'h00, do_level}, {6'h00, lvl});
      chk(img.next_pending_sequence, {2'b11, ent[f+k].seq[5:0] + 6'h01});
    end
    run = 1'b0;
  endtask : exec
  // hang guard, the whole sequence needs about 20000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {arst_n, run, piq_wr, piq_commit, param_rd, param_wr, param_idx, lvl} = '0;
    piq_addr = 6'h00;
    piq_data = 8'h00;
    err_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    cyc;
    chk(img.queued_entry_count, 8'h00);
    chk(img.next_pending_sequence, 8'hC0);
    param_get(ets_pkg::PARAM_IDX_IN, 8'h04);
    param_get(ets_pkg::PARAM_IDX_OUT, 8'h14);
    param_get(2'h2, 8'h00);
    param_wr = 1'b1;
    cyc;
    param_wr = 1'b0;
    chk({7'h00, param_reject}, 8'h01);
    param_get(ets_pkg::PARAM_IDX_IN, 8'h04);
    $display("test parameter record done");
    wr_byte(6'h14, 8'hFF);
    load(0, 5);
    chk(img.queued_entry_count, 8'h05);
    chk(img.last_received_sequence, 8'h45);
    chk(img.queue_status, 8'h00);
    exec(0, 5);
    chk(img.queue_status, 8'h02);
    $display("test full batch done");
    load(5, 3);
    chk(img.queued_entry_count, 8'h03);
    chk(img.last_received_sequence, 8'h48);
    chk(img.queue_status, 8'h82);
    exec(5, 3);
    $display("test short batch done");
    // refill far ahead of the stopped ticker until the queue is full and copying stalls
    load(8, 5);
    for (int r = 2; r < 7; r++) begin
      piq_commit = 1'b1;
      cyc;
      piq_commit = 1'b0;
      wait_cnt(8'(5 * r));
    end
    piq_commit = 1'b1;
    cyc;
    piq_commit = 1'b0;
    wait_cnt(8'h20);
    chk({7'h00, copy_busy}, 8'h01);
    chk(img.queue_status, 8'h06);
    chk(img.last_received_sequence, 8'h54);
    // let the ticker wrap to the targets and drain all 35 entries
    run = 1'b1;
    wait_cnt(8'h00);
    run = 1'b0;
    chk({6'h00, do_level}, {6'h00, lvl});
    chk(img.next_pending_sequence, 8'hD5);
    chk(img.queue_status, 8'h02);
    $display("test full queue done");
    report_and_stop;
  end
endmodule : timestamped_output_scheduler_test

bind timestamped_output_scheduler ets_sched_sva #(.LARGE_IMAGE(LARGE_IMAGE)) ets_sched_sva_inst (.clk, .arst_n,
  .us_ticker, .piq_wr, .piq_addr, .piq_data, .piq_commit, .param_rd, .param_idx, .param_wr,
  .input_process_image, .param_data, .param_reject, .copy_busy, .do_level);
